// *** downstream_sink.sv ***
// downstream sink model for the outgoing byte bus
`timescale 1ns/1ns
`default_nettype none

module downstream_sink (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst_n,
    // bench control
    input  wire logic stall_en,
    // byte bus
    output logic      out_ready
);
    logic [5:0] cnt_reg;

    // stalls half of every 64 cycles so that the fifo runs full
    always @(posedge core_clk) begin
        cnt_reg   <= rst_n ? cnt_reg + 6'h01 : 6'h00;
        out_ready <= rst_n && (!stall_en || cnt_reg[5]);
    end
endmodule
`default_nettype wire

// *** outgoing_bus_defines.vh ***
// register map, field positions and frame geometry for the outgoing bus block
`ifndef OUTGOING_BUS_DEFINES_VH
`define OUTGOING_BUS_DEFINES_VH

// ----------------------------------------------------------------------------
// register offsets (7-bit register address)
// ----------------------------------------------------------------------------
`define ADDR_W              7
`define ADDR_CONFIG         7'h60
`define ADDR_J1_MARK        7'h61
`define ADDR_POST_J1_MARK   7'h62
`define ADDR_PRIMARY_PTR    7'h63
`define ADDR_ALTERNATE_PTR  7'h64
`define ADDR_PTR_SELECT     7'h65
`define ADDR_MODE_CONTROL   7'h66
`define ADDR_STATUS         7'h67

// ----------------------------------------------------------------------------
// field positions and masks
// ----------------------------------------------------------------------------
`define REG_W               16
`define REG_RESET           16'h0000
`define CFG_WRITE_MASK      16'hcfff
`define CFG_J1_LOCK_BIT     14
`define CFG_FP_INCL_BIT     8
`define CFG_PL_INCL_BIT     4
`define CFG_ODD_BIT         0
`define STS_MASK            16'h0fff
`define SEL_WRITE_MASK      16'h8fff
`define SEL_INSERT_EN_BIT   15
`define MODE_SONET_BIT      0
`define PTR_H1_HI           15
`define PTR_H1_LO           8
`define PTR_H2_HI           7
`define PTR_H2_LO           0
`define MODE_WRITE_MASK     16'h0001
`define WORD_W              11
`define WORD_FS_BIT         10
`define WORD_PL_BIT         9
`define WORD_V5_BIT         8
`define WORD_DATA_HI        7
`define WORD_DATA_LO        0

// ----------------------------------------------------------------------------
// frame geometry: row index 0 is the first row, groups are 12 bytes wide
// ----------------------------------------------------------------------------
`define ROW_FIRST           4'h0
`define ROW_POINTER         4'h3
`define GRP_H1              7'h00
`define GRP_H2              7'h01
`define GRP_C1              7'h02
`define GRP_J1              7'h03
`define GRP_POST_J1         7'h04

`endif

// *** outgoing_bus_overhead_parity.v ***
// outgoing byte bus stage: pointer insertion, frame-pulse marks and parity
//
// Overview of operation
// - sonet mode payload bit parity per include
// - odd select one gives odd parity
// - tributary mode parity covers data, payload, v5
// - sonet parity: data plus optional payload, pulse
// - sonet mode always pulses at every c1
// - per-sts j1 mark enable pulses at j1
// - per-sts post-j1 enable pulses after j1
// - j1 located from c1 via offset lock
// - j1 marks act only in sonet mode
// - insert enable overwrites h1/h2 in sonet mode
// - per-sts select picks primary or alternate
// - primary pointer: h1 high byte, h2 low
// - alternate pointer uses same byte layout
// - lock one: after h3; zero: after c1
// - frame pulse enters sonet parity when included
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "outgoing_bus_defines.vh"

// ----------------------------------------------------------------------------
// byte fifo between the switch path and the output stage
// ----------------------------------------------------------------------------
// one entry per byte: frame start, payload and v5 travel with it,
// so back-pressure can never split a byte from its side bits
module stream_fifo #(
    parameter WIDTH = 11,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    // clock and reset
    input  wire              core_clk,
    input  wire              rst_n,
    // fill side
    input  wire              wr_valid,
    output wire              wr_ready,
    input  wire [WIDTH-1:0]  wr_data,
    // drain side
    output wire              rd_valid,
    input  wire              rd_ready,
    output wire [WIDTH-1:0]  rd_data,
    // fill level
    output wire [AW:0]       level
);
    reg  [WIDTH-1:0] mem [0:DEPTH-1];
    reg  [AW-1:0]    wr_ptr_reg;
    reg  [AW-1:0]    rd_ptr_reg;
    reg  [AW:0]      count_reg;
    wire             push;
    wire             pop;

    // a push into a full fifo is refused by wr_ready, never dropped
    // full and empty come straight from the count, so they never lie
    assign wr_ready = (count_reg != DEPTH[AW:0]);
    assign rd_valid = (count_reg != {(AW+1){1'b0}});
    assign push     = wr_valid & wr_ready;
    assign pop      = rd_valid & rd_ready;
    assign rd_data  = mem[rd_ptr_reg];
    assign level    = count_reg;

    // stale words are never read: rd_valid guards every pop
    // storage write, no reset needed on data
    always @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= wr_data;
        end
    end

    // limitation: a depth that is not a power of two needs its own wrap
    // pointers wrap naturally because depth is a power of two
    always @(posedge core_clk) begin
        if (!rst_n) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            case ({push, pop})
                2'b10:   count_reg <= count_reg + 1'b1;
                2'b01:   count_reg <= count_reg - 1'b1;
                default: count_reg <= count_reg;
            endcase
        end
    end
endmodule

// ----------------------------------------------------------------------------
// top level
// ----------------------------------------------------------------------------
// the output slice decides pointer overwrite, frame pulse and parity
// from the fifo head and its frame position in the cycle it is taken;
// all five outputs load together, so parity never lags its byte
// and a far-side stall never tears a byte from its side bits
module outgoing_bus_overhead_parity #(
    parameter STS_COUNT  = 12,
    parameter FRAME_COLS = 1080,
    parameter FRAME_ROWS = 9,
    parameter FIFO_DEPTH = 32,
    parameter FIFO_AW    = 5
) (
    // clock and reset
    input  wire                 core_clk,
    input  wire                 rst_n,
    // register port
    input  wire [`ADDR_W-1:0]   reg_addr,
    input  wire [`REG_W-1:0]    reg_wr_data,
    input  wire                 reg_wr,
    input  wire                 reg_rd,
    output reg  [`REG_W-1:0]    reg_rd_data,
    // stream from the internal switch path
    input  wire                 in_valid,
    output wire                 in_ready,
    input  wire [7:0]           in_data,
    input  wire                 in_payload,
    input  wire                 in_v5,
    input  wire                 in_frame_start,
    // outgoing byte bus
    output reg                  out_valid,
    input  wire                 out_ready,
    output reg  [7:0]           outgoing_data_byte,
    output reg                  payload_indicator_out,
    output reg                  v5_indicator_out,
    output reg                  composite_frame_pulse_out,
    output reg                  outgoing_parity_out
);
    // derived limits; counters compare against these, not their widths
    localparam FIFO_W = `WORD_W;
    localparam LAST_COL = FRAME_COLS - 1;
    localparam LAST_ROW = FRAME_ROWS - 1;
    localparam LAST_STS = STS_COUNT - 1;

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    reg  [`REG_W-1:0] config_reg;
    reg  [`REG_W-1:0] j1_mark_reg;
    reg  [`REG_W-1:0] post_j1_mark_reg;
    reg  [`REG_W-1:0] primary_ptr_reg;
    reg  [`REG_W-1:0] alternate_ptr_reg;
    reg  [`REG_W-1:0] ptr_select_reg;
    reg  [`REG_W-1:0] mode_reg;
    reg  [`REG_W-1:0] rd_next;

    // col runs over the row; sts and grp split col into groups of sts
    // frame position of the next byte to leave
    reg  [10:0] col_reg;
    reg  [3:0]  row_reg;
    reg  [3:0]  sts_reg;
    reg  [6:0]  grp_reg;

    // fifo hookup
    wire [FIFO_W-1:0]  fifo_out;
    wire               fifo_valid;
    wire               take;
    wire [FIFO_AW:0]   fifo_level;

    // bit positions live in the defines header beside the register map
    // decoded control bits
    wire sonet_mode     = mode_reg[`MODE_SONET_BIT];
    wire j1_lock        = config_reg[`CFG_J1_LOCK_BIT];
    wire fp_incl        = config_reg[`CFG_FP_INCL_BIT];
    wire pl_incl        = config_reg[`CFG_PL_INCL_BIT];
    wire odd_sel        = config_reg[`CFG_ODD_BIT];
    wire insert_en      = ptr_select_reg[`SEL_INSERT_EN_BIT];

    // byte taken from the fifo and its position in the frame
    wire       b_fs   = fifo_out[`WORD_FS_BIT];
    wire       b_pl   = fifo_out[`WORD_PL_BIT];
    wire       b_v5   = fifo_out[`WORD_V5_BIT];
    wire [7:0] b_data = fifo_out[`WORD_DATA_HI:`WORD_DATA_LO];
    wire [10:0] p_col = b_fs ? 11'h000 : col_reg;
    wire [3:0]  p_row = b_fs ? 4'h0 : row_reg;
    wire [3:0]  p_sts = b_fs ? 4'h0 : sts_reg;
    wire [6:0]  p_grp = b_fs ? 7'h00 : grp_reg;

    // ------------------------------------------------------------------------
    // fifo in the data path; the output stage drains it under back-pressure
    // ------------------------------------------------------------------------
    // level is exported only for the status register
    stream_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .wr_valid (in_valid),
        .wr_ready (in_ready),
        .wr_data  ({in_frame_start, in_payload, in_v5, in_data}),
        .rd_valid (fifo_valid),
        .rd_ready (take),
        .rd_data  (fifo_out),
        .level    (fifo_level)
    );

    // no skid stage: in_ready depends on the fifo count, not on out_ready
    // output stage loads when empty or when downstream takes its byte
    assign take = fifo_valid & (~out_valid | out_ready);

    // ------------------------------------------------------------------------
    // overhead position decode
    // ------------------------------------------------------------------------
    // positions advance per accepted byte, not per clock, so far-side
    // stalls cannot push a mark onto the wrong byte
    // j1 row moves with the offset lock; the mark group is fixed after c1/h3
    wire [3:0] j1_row    = j1_lock ? `ROW_POINTER : `ROW_FIRST;
    wire at_c1     = (p_row == `ROW_FIRST) && (p_grp == `GRP_C1);
    wire at_j1     = (p_row == j1_row) && (p_grp == `GRP_J1);
    wire at_post   = (p_row == j1_row) && (p_grp == `GRP_POST_J1);
    wire at_h1     = (p_row == `ROW_POINTER) && (p_grp == `GRP_H1);
    wire at_h2     = (p_row == `ROW_POINTER) && (p_grp == `GRP_H2);

    // bit k of each per-sts register belongs to the k-th sts of a group
    // per-sts enables picked by the current sts index
    wire j1_en     = j1_mark_reg[p_sts];
    wire post_en   = post_j1_mark_reg[p_sts];
    wire alt_sel   = ptr_select_reg[p_sts];

    // tributary mode keeps c1 so a downstream framer can still align
    // frame pulse: c1 always, j1 marks only in sonet mode
    wire fp_next   = at_c1
                   | (sonet_mode & at_j1 & j1_en)
                   | (sonet_mode & at_post & post_en);

    // insertion reads the pointer registers live; change them away from
    // the pointer row, or an h1/h2 pair may come from two settings
    // pointer overwrite; otherwise the switch path byte goes through
    wire [7:0] h1_val = alt_sel ? alternate_ptr_reg[`PTR_H1_HI:`PTR_H1_LO]
                                : primary_ptr_reg[`PTR_H1_HI:`PTR_H1_LO];
    wire [7:0] h2_val = alt_sel ? alternate_ptr_reg[`PTR_H2_HI:`PTR_H2_LO]
                                : primary_ptr_reg[`PTR_H2_HI:`PTR_H2_LO];
    wire       do_ins = sonet_mode & insert_en;
    wire [7:0] data_next = (do_ins & at_h1) ? h1_val :
                           (do_ins & at_h2) ? h2_val : b_data;

    // odd parity is the even result inverted: one xor tree for both
    // parity over the exact values about to be driven
    wire cover_sonet = (^data_next)
                     ^ (pl_incl & b_pl)
                     ^ (fp_incl & fp_next);
    wire cover_trib  = (^data_next) ^ b_pl ^ b_v5;
    wire even_par    = sonet_mode ? cover_sonet : cover_trib;
    wire par_next    = odd_sel ? ~even_par : even_par;

    // ------------------------------------------------------------------------
    // output stage
    // ------------------------------------------------------------------------
    // a held byte keeps every output still until the far side takes it
    // every output is a flop so parity always matches the byte beside it
    always @(posedge core_clk) begin
        if (!rst_n) begin
            out_valid                 <= 1'b0;
            outgoing_data_byte        <= 8'h00;
            payload_indicator_out     <= 1'b0;
            v5_indicator_out          <= 1'b0;
            composite_frame_pulse_out <= 1'b0;
            outgoing_parity_out       <= 1'b0;
        end else if (take) begin
            out_valid                 <= 1'b1;
            outgoing_data_byte        <= data_next;
            payload_indicator_out     <= b_pl;
            v5_indicator_out          <= b_v5;
            composite_frame_pulse_out <= fp_next;
            outgoing_parity_out       <= par_next;
        end else if (out_ready) begin
            out_valid                 <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // frame position counters
    // ------------------------------------------------------------------------
    // limitation: with no frame start at all the counters free-run from
    // reset, so marks fall on counted positions, not on real overhead;
    // the stream source must mark the first byte of every frame
    // frame start re-aligns everything, so a slip heals on the next frame
    always @(posedge core_clk) begin
        if (!rst_n) begin
            col_reg <= 11'h000;
            row_reg <= 4'h0;
            sts_reg <= 4'h0;
            grp_reg <= 7'h00;
        end else if (take) begin
            if (p_sts == LAST_STS[3:0]) begin
                sts_reg <= 4'h0;
                grp_reg <= p_grp + 7'h01;
            end else begin
                sts_reg <= p_sts + 4'h1;
                grp_reg <= p_grp;
            end
            if (p_col == LAST_COL[10:0]) begin
                col_reg <= 11'h000;
                sts_reg <= 4'h0;
                grp_reg <= 7'h00;
                row_reg <= (p_row == LAST_ROW[3:0]) ? 4'h0 : p_row + 4'h1;
            end else begin
                col_reg <= p_col + 11'h001;
                row_reg <= p_row;
            end
        end
    end

    // ------------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------------
    // a new setting applies from the next byte taken; a byte already in
    // the output slice keeps the settings it was built with
    // unused bits are masked on write so they read back as zero; config keeps its unused bits 15, 11-9, 7-5 and 3-1
    always @(posedge core_clk) begin
        if (!rst_n) begin
            config_reg        <= `REG_RESET;
            j1_mark_reg       <= `REG_RESET;
            post_j1_mark_reg  <= `REG_RESET;
            primary_ptr_reg   <= `REG_RESET;
            alternate_ptr_reg <= `REG_RESET;
            ptr_select_reg    <= `REG_RESET;
            mode_reg          <= `REG_RESET;
        end else if (reg_wr) begin
            case (reg_addr)
                `ADDR_CONFIG:        config_reg        <= reg_wr_data & `CFG_WRITE_MASK;
                `ADDR_J1_MARK:       j1_mark_reg       <= reg_wr_data & `STS_MASK;
                `ADDR_POST_J1_MARK:  post_j1_mark_reg  <= reg_wr_data & `STS_MASK;
                `ADDR_PRIMARY_PTR:   primary_ptr_reg   <= reg_wr_data;
                `ADDR_ALTERNATE_PTR: alternate_ptr_reg <= reg_wr_data;
                `ADDR_PTR_SELECT:    ptr_select_reg    <= reg_wr_data & `SEL_WRITE_MASK;
                `ADDR_MODE_CONTROL:  mode_reg          <= reg_wr_data & `MODE_WRITE_MASK;
                default:             mode_reg          <= mode_reg;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------------------
    // status is read only: fifo fill level in the upper byte, row below
    // read mux; unmapped offsets answer zero
    always @* begin
        case (reg_addr)
            `ADDR_CONFIG:        rd_next = config_reg;
            `ADDR_J1_MARK:       rd_next = j1_mark_reg;
            `ADDR_POST_J1_MARK:  rd_next = post_j1_mark_reg;
            `ADDR_PRIMARY_PTR:   rd_next = primary_ptr_reg;
            `ADDR_ALTERNATE_PTR: rd_next = alternate_ptr_reg;
            `ADDR_PTR_SELECT:    rd_next = ptr_select_reg;
            `ADDR_MODE_CONTROL:  rd_next = mode_reg;
            `ADDR_STATUS:        rd_next = {2'b00, fifo_level, 4'h0, row_reg};
            default:             rd_next = `REG_RESET;
        endcase
    end

    // zero outside the answer cycle keeps a shared read bus quiet
    // read data stands only in the cycle after the strobe
    always @(posedge core_clk) begin
        if (!rst_n) begin
            reg_rd_data <= `REG_RESET;
        end else if (reg_rd) begin
            reg_rd_data <= rd_next;
        end else begin
            reg_rd_data <= `REG_RESET;
        end
    end
endmodule
`default_nettype wire

// *** outgoing_bus_overhead_parity_tb.sv ***
// self-checking bench for the outgoing bus overhead and parity stage
`timescale 1ns/1ns
`default_nettype none

module outgoing_bus_overhead_parity_tb;
    logic        core_clk, rst_n, reg_wr, reg_rd, stall_en, saw_full;
    logic [6:0]  reg_addr;
    logic [15:0] reg_wr_data, reg_rd_data;
    logic        in_valid, in_ready, in_payload, in_v5, in_frame_start;
    logic [7:0]  in_data, outgoing_data_byte;
    logic        out_valid, out_ready, payload_indicator_out, v5_indicator_out;
    logic        composite_frame_pulse_out, outgoing_parity_out;
    logic [15:0] cv [7];
    logic [11:0] exp_q [$];
    int          num_errors, checked, cycles, tests;
    localparam logic [15:0] RB [7] = '{16'hcfff, 16'h0fff, 16'h0fff, 16'hffff,
                                       16'hffff, 16'h8fff, 16'h0001};

    outgoing_bus_overhead_parity outgoing_bus_overhead_parity_i (
        .core_clk, .rst_n, .reg_addr, .reg_wr_data, .reg_wr, .reg_rd, .reg_rd_data,
        .in_valid, .in_ready, .in_data, .in_payload, .in_v5, .in_frame_start,
        .out_valid, .out_ready, .outgoing_data_byte, .payload_indicator_out,
        .v5_indicator_out, .composite_frame_pulse_out, .outgoing_parity_out);
    downstream_sink downstream_sink_i (.core_clk, .rst_n, .stall_en, .out_ready);

    // ----------
    // helpers
    // ----------
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        checked++;
        if (seen !== want) begin
            num_errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, want);
        end
    endtask

    task conclude();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_wr      <= 1'b1;
        reg_addr    <= a;
        reg_wr_data <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task rd(input logic [6:0] a, input logic [15:0] want);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(posedge core_clk);
        check(reg_rd_data, want);
    endtask

    // expected {data, payload, v5, pulse, parity} for frame byte p
    function automatic logic [11:0] expect_byte(int p, logic [7:0] d, logic pl, logic v5);
        int          row, grp, sts;
        logic [15:0] ptr;
        logic        son, fp;
        row = p / 1080;
        grp = (p % 1080) / 12;
        sts = (p % 1080) % 12;
        son = cv[6][0];
        ptr = cv[5][sts] ? cv[4] : cv[3];
        if (son && cv[5][15] && row == 3 && grp < 2) d = (grp == 0) ? ptr[15:8] : ptr[7:0];
        fp = (row == 0 && grp == 2) || (son && row == (cv[0][14] ? 3 : 0)
             && ((grp == 3 && cv[1][sts]) || (grp == 4 && cv[2][sts])));
        return {d, pl, v5, fp, cv[0][0] ^ (^d) ^ (son ? (pl & cv[0][4]) ^ (fp & cv[0][8])
                : pl ^ v5)};
    endfunction

    // frame bytes from a frame start; only accepted bytes advance
    task send(input int n);
        for (int i = 0; i < n; i++) begin
            in_valid       <= 1'b1;
            in_frame_start <= (i == 0);
            in_data        <= 8'(i * 7 + 3);
            in_payload     <= i[3];
            in_v5          <= i[5];
            do @(posedge core_clk); while (!in_ready);
            exp_q.push_back(expect_byte(i, 8'(i * 7 + 3), i[3], i[5]));
        end
        in_valid       <= 1'b0;
        in_frame_start <= 1'b0;
    endtask

    // configure, stream 3300 bytes (three rows and 60 bytes of row 3) and wait for the sink to drain
    task run(input logic [15:0] mo, cf, a, b, pp, al, sl, input logic st);
        cv = '{cf, a, b, pp, al, sl, mo};
        for (int i = 0; i < 7; i++) wr(7'h60 + 7'(i), cv[i]);
        stall_en <= st;
        send(3300);
        while (exp_q.size() != 0) @(posedge core_clk);
        tests++;
        $display("test %0d done", tests);
    endtask

    // ----------
    // clock, watchdog, scoreboard
    // ----------
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // two full-rate and two half-rate runs fit far below this ceiling
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 60000) begin
            num_errors++;
            conclude();
        end
    end

    // compare every byte the sink takes
    always @(posedge core_clk) begin
        if (rst_n && !in_ready) saw_full = 1'b1;
        if (rst_n && out_valid && out_ready) begin
            if (exp_q.size() == 0) check(16'h0001, 16'h0000);
            else begin
                check(outgoing_data_byte, exp_q[0][11:4]);
                check(composite_frame_pulse_out, exp_q[0][1]);
                check(outgoing_parity_out, exp_q[0][0]);
                check({payload_indicator_out, v5_indicator_out},
                      16'((exp_q.pop_front() >> 2) & 12'h003));
            end
        end
    end

    // ----------
    // main sequence
    // ----------
    initial begin
        {rst_n, reg_wr, reg_rd, stall_en, in_valid, in_frame_start, in_payload, in_v5} = '0;
        {reg_addr, reg_wr_data, in_data, saw_full} = '0;
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        for (int a = 1; a < 6; a++) rd(7'h60 + 7'(a), 16'h0000);
        for (int a = 0; a < 7; a++) begin
            wr(7'h60 + 7'(a), 16'hffff);
            rd(7'h60 + 7'(a), RB[a]);
        end
        wr(7'h70, 16'hffff);
        rd(7'h70, 16'h0000);
        $display("register test done");
        run(16'h0000, 16'h4111, 16'h0fff, 16'h0fff, 16'h1234, 16'habcd, 16'h8fff, 0);
        run(16'h0001, 16'h4010, 16'h0a5a, 16'h05a5, 16'h1234, 16'habcd, 16'h80f0, 1);
        run(16'h0001, 16'h0101, 16'h0fff, 16'h0801, 16'h1234, 16'habcd, 16'h0fff, 1);
        run(16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h00ff, 16'hff00, 16'h8f0f, 0);
        rd(7'h67, 16'h0003); // status: fifo drained, row 3 after 3300 bytes
        check(saw_full, 1'b1);
        conclude();
    end
endmodule
`default_nettype wire

// *** overhead_bus_asserts.sv ***
// assertion checker for the outgoing bus overhead and parity stage
`timescale 1ns/1ns
`default_nettype none

module overhead_bus_asserts (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        rst_n,
    // register port
    input wire logic [6:0]  reg_addr,
    input wire logic [15:0] reg_wr_data,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rd_data,
    // stream
    input wire logic        in_valid,
    input wire logic        in_ready,
    input wire logic        out_valid,
    input wire logic        out_ready,
    input wire logic [7:0]  outgoing_data_byte,
    input wire logic        payload_indicator_out,
    input wire logic        v5_indicator_out,
    input wire logic        composite_frame_pulse_out,
    input wire logic        outgoing_parity_out
);
    logic [15:0] m_reg [0:7];
    logic [15:0] rd_exp;
    logic        dpar;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // stored bits per offset; status at 7 is not mirrored
    function automatic logic [15:0] wmask(input logic [2:0] a);
        case (a)
            3'h0: return 16'hcfff;
            3'h1, 3'h2: return 16'h0fff;
            3'h5: return 16'h8fff;
            3'h6: return 16'h0001;
            3'h7: return 16'h0000;
            default: return 16'hffff;
        endcase
    endfunction

    // mirror of the writable registers
    always @(posedge core_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 8; i++) m_reg[i] <= 16'h0000;
        end else if (reg_wr && reg_addr[6:3] == 4'hc) begin
            m_reg[reg_addr[2:0]] <= reg_wr_data & wmask(reg_addr[2:0]);
        end
    end

    // read expectation and data parity
    assign rd_exp = m_reg[reg_addr[2:0]];
    assign dpar   = ^outgoing_data_byte;

    rd_idle_a: assert property (!$past(reg_rd) |-> reg_rd_data == 16'h0000)
        else $error("read data outside its cycle");
    rd_back_a: assert property (reg_rd && reg_addr[6:3] == 4'hc && reg_addr[2:0] != 3'h7
        |=> reg_rd_data == $past(rd_exp)) else $error("register read back wrong");
    unmapped_rd_a: assert property (reg_rd && reg_addr[6:3] != 4'hc |=> reg_rd_data == 16'h0000)
        else $error("unmapped read not zero");
    out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable({
        outgoing_data_byte, payload_indicator_out, v5_indicator_out,
        composite_frame_pulse_out, outgoing_parity_out})) else $error("output moved while stalled");
    out_drop_a: assert property ($fell(out_valid) |-> $past(out_ready))
        else $error("byte dropped without acceptance");
    fill_delay_a: assert property ($rose(out_valid) |-> $past(in_valid && in_ready, 2))
        else $error("output byte without input two cycles before");
    reset_state_a: assert property ($rose(rst_n) |-> !out_valid && in_ready
        && !composite_frame_pulse_out && !outgoing_parity_out) else $error("bad reset state");
    trib_parity_a: assert property (out_valid && !m_reg[6][0] |-> outgoing_parity_out ==
        (m_reg[0][0] ^ dpar ^ payload_indicator_out ^ v5_indicator_out))
        else $error("tributary parity wrong");
    sonet_parity_a: assert property (out_valid && m_reg[6][0] |-> outgoing_parity_out ==
        (m_reg[0][0] ^ dpar ^ (payload_indicator_out & m_reg[0][4])
        ^ (composite_frame_pulse_out & m_reg[0][8]))) else $error("framed parity wrong");
endmodule

bind outgoing_bus_overhead_parity overhead_bus_asserts overhead_bus_asserts_i (
    .core_clk, .rst_n, .reg_addr, .reg_wr_data, .reg_wr, .reg_rd, .reg_rd_data,
    .in_valid, .in_ready, .out_valid, .out_ready, .outgoing_data_byte,
    .payload_indicator_out, .v5_indicator_out, .composite_frame_pulse_out,
    .outgoing_parity_out);
`default_nettype wire
